//--- sim/sdd_glass.sv
// passive glass model: integrates backplane minus column level per pixel
// assumes pin levels are sampled once per core clock, clear pulsed once
`timescale 1ns/10ps
module sdd_glass (
    // clock and clear
    input wire logic i_core_clk,
    input wire logic i_clr,
    // pins from the driver
    input wire sdd_pkg::sdd_pin_type [7:0] i_bp_pin,
    input wire sdd_pkg::sdd_pin_type [7:0] i_col_pin,
    // per pixel net dc and squared drive
    output int o_dc [8][8],
    output int o_sq [8][8]
);
    int d;
    // glass only integrates, so any dc offset shows as a growing sum
    always @(posedge i_core_clk) begin
        for (int b = 0; b < 8; b++) begin
            for (int c = 0; c < 8; c++) begin
                d = int'(i_bp_pin[b].level) - int'(i_col_pin[c].level);
                o_dc[b][c] <= i_clr ? 0 : o_dc[b][c] + d;
                o_sq[b][c] <= i_clr ? 0 : o_sq[b][c] + d * d;
            end
        end
    end
endmodule : sdd_glass

//--- sim/testbench.sv
// self-checking bench for the segment display driver with a glass model
// assumes register map and level coding of the design package
`timescale 1ns/10ps
module testbench;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic secondary_oscillator = 1'b0;
    logic lfosc = 1'b0;
    logic [2:0] ocnt = 3'h0;
    logic clr = 1'b1;
    logic mon = 1'b0;
    logic ph;
    logic [1:0] lx;
    sdd_pkg::sdd_pin_type [7:0] bp_pin;
    sdd_pkg::sdd_pin_type [7:0] col_pin;
    int dc [8][8];
    int sq [8][8];
    int dcs [8][8];
    int sqs [8][8];
    int n_fail = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [31:0] seed = 32'h4a23;
    logic [7:0] pix [8];
    logic [7:0] v;
    logic [7:0] m;
    logic [7:0] o;
    int t0;
    int t1;
    int sel [4] = '{1, 2, 3, 8};
    int pre [4] = '{0, 1, 1, 0};
    int tyb [4] = '{0, 1, 0, 1};
    int src [4] = '{0, 1, 0, 0};

    sdd_top dut_u (.i_core_clk(core_clk), .i_rstn(rstn), .i_ce(ce), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_secondary_oscillator(secondary_oscillator), .i_lfosc(lfosc), .i_bp_pin_in(8'h00),
        .i_col_pin_in(8'h00), .o_bp_pin(bp_pin), .o_col_pin(col_pin));
    sdd_glass glass_u (.i_core_clk(core_clk), .i_clr(clr), .i_bp_pin(bp_pin), .i_col_pin(col_pin),
        .o_dc(dc), .o_sq(sq));

    always #5 core_clk = ~core_clk;

    // slow oscillators: secondary every 4 core cycles, low-freq every 8
    always @(posedge core_clk) begin
        ocnt <= ocnt + 3'h1;
        secondary_oscillator <= ocnt[1];
        lfosc <= ocnt[2];
        cyc <= cyc + 1;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // field 0 display ownership, 1 output enable, 2 gpio output value
    function automatic logic [7:0] bits(input sdd_pkg::sdd_pin_type [7:0] p, input int f);
        for (int i = 0; i < 8; i++) bits[i] = (f == 2) ? p[i].out : (f == 1) ? p[i].oe_n : p[i].lcd;
    endfunction : bits

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_n(input int got, input int exp);
        total_checks++;
        if (got != exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_n

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        @(negedge core_clk);
        d = rdata;
    endtask : rd_reg

    // pins follow a write two edges after its strobe
    task automatic settle();
        @(posedge core_clk);
        @(negedge core_clk);
    endtask : settle

    // marker: backplane 0 entering active phase 0, once a frame in type A, every second in type B
    task automatic wait_mark(output int t);
        logic [1:0] last;
        last = bp_pin[0].level;
        for (int i = 0; i < 20000; i++) begin
            @(posedge core_clk);
            if (bp_pin[0].level == sdd_pkg::LVL_3 && last != sdd_pkg::LVL_3) break;
            last = bp_pin[0].level;
        end
        t = cyc;
    endtask : wait_mark

    task automatic finish_test();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : finish_test

    // active backplane row must be mirrored on the columns, set bit dark
    always @(posedge core_clk) begin
        if (mon) begin
            for (int b = 0; b < 8; b++) begin
                if (bp_pin[b].lcd && (bp_pin[b].level == sdd_pkg::LVL_3 || bp_pin[b].level == sdd_pkg::LVL_0)) begin
                    ph = (bp_pin[b].level == sdd_pkg::LVL_0);
                    for (int c = 0; c < 8; c++) begin
                        lx = pix[b][c] ? (ph ? sdd_pkg::LVL_3 : sdd_pkg::LVL_0) : (ph ? sdd_pkg::LVL_1 : sdd_pkg::LVL_2);
                        chk({6'h00, col_pin[c].level}, {6'h00, lx});
                    end
                end
            end
        end
    end

    initial begin
        repeat (100000) @(posedge core_clk);
        n_fail++;
        finish_test();
    end

    initial begin
        repeat (5) @(posedge core_clk);
        rstn <= 1'b1;
        clr <= 1'b0;
        rd_reg(sdd_pkg::ADDR_CTRL, v);
        chk(v, 8'h00);
        rd_reg(sdd_pkg::ADDR_SEG_EN, v);
        chk(v, 8'h00);
        rd_reg(sdd_pkg::ADDR_STATUS, v);
        chk(v, 8'h00);
        chk(bits(col_pin, 1'b0), 8'h00);
        m = rnd();
        wr_reg(sdd_pkg::ADDR_BP_DIR, m);
        for (int s = 0; s < 16; s++) begin
            wr_reg(sdd_pkg::ADDR_CTRL, 8'(s));
            settle();
            v = (s > 8) ? 8'h00 : 8'((9'h001 << s) - 9'h001);
            chk(bits(bp_pin, 1'b0), v);
            chk(bits(bp_pin, 1'b1), m & ~v);
        end
        for (int i = 0; i < 4; i++) begin
            v = rnd();
            m = rnd();
            o = rnd();
            wr_reg(sdd_pkg::ADDR_SEG_EN, v);
            wr_reg(sdd_pkg::ADDR_COL_DIR, m);
            wr_reg(sdd_pkg::ADDR_COL_OUT, o);
            settle();
            chk(bits(col_pin, 1'b0), v);
            chk(bits(col_pin, 1'b1), m & ~v);
            chk(bits(col_pin, 2), o & ~v);
        end
        for (int b = 0; b < 8; b++) begin
            pix[b] = rnd();
            if (b == 0) pix[b] = (pix[b] | 8'h01) & 8'hfd;
            wr_reg(sdd_pkg::ADDR_PIX_BASE + 8'(b), pix[b]);
        end
        for (int b = 0; b < 8; b++) begin
            rd_reg(sdd_pkg::ADDR_PIX_BASE + 8'(b), v);
            chk(v, pix[b]);
        end
        wr_reg(sdd_pkg::ADDR_SEG_EN, 8'hff);
        for (int k = 0; k < 4; k++) begin
            mon <= 1'b0;
            wr_reg(sdd_pkg::ADDR_PRESC, 8'(pre[k]));
            wr_reg(sdd_pkg::ADDR_CTRL, {1'b1, 1'b0, 1'(src[k]), 1'(tyb[k]), 4'(sel[k])});
            wait_mark(t0);
            wait_mark(t0);
            mon <= 1'b1;
            dcs = dc;
            sqs = sq;
            wait_mark(t1);
            // K is 4 for one backplane, 2 for two, 1 above; source tick is 32 oscillator periods
            chk_n(t1 - t0, (tyb[k] + 1) * sel[k] * (sel[k] == 1 ? 4 : sel[k] == 2 ? 2 : 1) * (pre[k] + 1)
                * 32 * (src[k] ? 8 : 4));
            for (int b = 0; b < sel[k]; b++) begin
                for (int c = 0; c < 8; c++) begin
                    chk_n(dc[b][c] - dcs[b][c], 0);
                end
            end
            chk_n(int'(sq[0][0] - sqs[0][0] > sq[0][1] - sqs[0][1]), 1);
        end
        mon <= 1'b0;
        finish_test();
    end
endmodule : testbench

//--- verilog/sdd_frame_div.sv
// frame clock source: picks one of two slow oscillators and divides its edges by 32
// assumes both oscillator inputs are synchronous levels far slower than the core clock
`timescale 1ns/10ps
module sdd_frame_div (
    // clock, reset, enable
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    // source selection and oscillators
    input wire logic i_src_lf,
    input wire logic i_secondary_oscillator,
    input wire logic i_lfosc,
    // one tick per 32 source edges
    output logic o_tick
);

    logic src_reg;
    logic [4:0] div_reg;
    logic [5:0] edge_cnt_reg;

    wire src_now = i_src_lf ? i_lfosc : i_secondary_oscillator;
    wire src_edge = src_now && !src_reg;
    wire div_wrap = src_edge && (div_reg == 5'(sdd_pkg::OSC_DIV - 1));

    // switching source may add one stray edge; harmless for a display
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            src_reg <= 1'b0;
            div_reg <= 5'h00;
            o_tick <= 1'b0;
        end else if (i_ce) begin
            src_reg <= src_now;
            if (src_edge) begin
                div_reg <= div_wrap ? 5'h00 : div_reg + 5'h01;
            end
            o_tick <= div_wrap;
        end
    end

    // edges seen since the previous tick, only for checking
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            edge_cnt_reg <= 6'h00;
        end else if (i_ce) begin
            if (o_tick) begin
                edge_cnt_reg <= {5'h00, src_edge};
            end else if (src_edge) begin
                edge_cnt_reg <= edge_cnt_reg + 6'h01;
            end
        end
    end

    chk_div_thirty_two: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (i_ce && o_tick) |-> (edge_cnt_reg == 6'h20))
        else $error("frame source tick not after 32 oscillator edges");

endmodule : sdd_frame_div

//--- verilog/sdd_pin_mux.sv
// per-pin function select: display drive or general i/o under its direction bit
// assumes the caller registers the result before it reaches a pin
`timescale 1ns/10ps
module sdd_pin_mux #(
    parameter int W = 8
) (
    // per-pin controls
    input wire logic [W-1:0] i_lcd_en,
    input wire logic [W-1:0] i_dir,
    input wire logic [W-1:0] i_out,
    input wire logic [2*W-1:0] i_level,
    // resolved pin drive
    output sdd_pkg::sdd_pin_type [W-1:0] o_pin
);

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_pin
            // display use wins over the direction bit
            assign o_pin[i].lcd = i_lcd_en[i];
            assign o_pin[i].oe_n = i_lcd_en[i] ? 1'b0 : i_dir[i];
            assign o_pin[i].out = i_lcd_en[i] ? 1'b0 : i_out[i];
            assign o_pin[i].level = i_lcd_en[i] ? i_level[2*i+1 -: 2] : sdd_pkg::LVL_0;
        end
    endgenerate

endmodule : sdd_pin_mux

//--- verilog/sdd_pkg.sv
// shared constants, register map, carrier types and level coding for the segment display driver
// assumes an 8-bit register port with reads answered one cycle after the strobe
package sdd_pkg;

    // ****************************************************************
    // sizes
    // ****************************************************************
    localparam int NUM_BP = 8;
    localparam int NUM_COL = 8;
    localparam int DW = 8;
    localparam int AW = 8;
    localparam int OSC_DIV = 32;
    localparam logic [3:0] SEL_MAX = 4'h8;
    localparam logic [2:0] K_STATIC = 3'h4;
    localparam logic [2:0] K_HALF = 3'h2;
    localparam logic [2:0] K_MULTI = 3'h1;

    // ****************************************************************
    // register offsets, fields and reset values
    // ****************************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PRESC = 8'h01;
    localparam logic [7:0] ADDR_SEG_EN = 8'h02;
    localparam logic [7:0] ADDR_BP_DIR = 8'h03;
    localparam logic [7:0] ADDR_COL_DIR = 8'h04;
    localparam logic [7:0] ADDR_BP_OUT = 8'h05;
    localparam logic [7:0] ADDR_COL_OUT = 8'h06;
    localparam logic [7:0] ADDR_STATUS = 8'h07;
    localparam logic [7:0] ADDR_BP_IN = 8'h08;
    localparam logic [7:0] ADDR_COL_IN = 8'h09;
    localparam logic [7:0] ADDR_PIX_BASE = 8'h10;
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_TYPEB_BIT = 4;
    localparam int CTRL_SRC_BIT = 5;
    localparam int CTRL_EN_BIT = 7;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [3:0] PRESC_RST = 4'h0;
    localparam logic [7:0] SEG_EN_RST = 8'h00;
    localparam logic [7:0] DIR_RST = 8'hff;
    localparam logic [7:0] OUT_RST = 8'h00;

    // ****************************************************************
    // drive levels, one third bias, 0 is ground and 3 is full
    // ****************************************************************
    localparam logic [1:0] LVL_0 = 2'h0;
    localparam logic [1:0] LVL_1 = 2'h1;
    localparam logic [1:0] LVL_2 = 2'h2;
    localparam logic [1:0] LVL_3 = 2'h3;

    typedef struct packed {
        logic en;
        logic src_lf;
        logic type_b;
        logic [3:0] sel;
    } sdd_ctrl_type;

    typedef struct packed {
        logic lcd;
        logic oe_n;
        logic out;
        logic [1:0] level;
    } sdd_pin_type;

    // codes above eight are treated as no backplane at all
    function automatic logic [3:0] num_bp(input logic [3:0] sel);
        num_bp = (sel > SEL_MAX) ? 4'h0 : sel;
    endfunction : num_bp

    function automatic logic [7:0] bp_mask(input logic [3:0] sel);
        bp_mask = 8'((9'h001 << num_bp(sel)) - 9'h001);
    endfunction : bp_mask

    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
        reg_hit = (addr == off);
    endfunction : reg_hit

    function automatic logic [1:0] bp_level(input logic active, input logic phase);
        bp_level = active ? (phase ? LVL_0 : LVL_3) : (phase ? LVL_2 : LVL_1);
    endfunction : bp_level

    function automatic logic [1:0] col_level(input logic dark, input logic phase);
        col_level = dark ? (phase ? LVL_3 : LVL_0) : (phase ? LVL_1 : LVL_2);
    endfunction : col_level

endpackage : sdd_pkg

//--- verilog/sdd_top.sv
// segment display driver: registers, backplane sequencing, phasing and pin function
// assumes a plain register port, synchronous slow oscillator inputs and pads outside
`timescale 1ns/10ps

module sdd_top (
    // clock, reset, enable
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // slow oscillators
    input wire logic i_secondary_oscillator,
    input wire logic i_lfosc,
    // pad inputs
    input wire logic [7:0] i_bp_pin_in,
    input wire logic [7:0] i_col_pin_in,
    // pad drive
    output sdd_pkg::sdd_pin_type [7:0] o_bp_pin,
    output sdd_pkg::sdd_pin_type [7:0] o_col_pin
);

    // ****************************************************************
    // registers
    // ****************************************************************
    sdd_pkg::sdd_ctrl_type ctrl_reg;
    logic [3:0] presc_reg;
    logic [7:0] seg_en_reg;
    logic [7:0] bp_dir_reg;
    logic [7:0] col_dir_reg;
    logic [7:0] bp_out_reg;
    logic [7:0] col_out_reg;
    logic [7:0] pix_reg [sdd_pkg::NUM_BP];
    logic [6:0] slice_cnt_reg;
    logic [2:0] bp_idx_reg;
    logic phase_reg;
    logic frame_odd_reg;
    logic tick;

    wire wr_ctrl = i_wr && sdd_pkg::reg_hit(i_addr, sdd_pkg::ADDR_CTRL);
    wire wr_presc = i_wr && sdd_pkg::reg_hit(i_addr, sdd_pkg::ADDR_PRESC);
    wire wr_seg = i_wr && sdd_pkg::reg_hit(i_addr, sdd_pkg::ADDR_SEG_EN);
    wire wr_bp_dir = i_wr && sdd_pkg::reg_hit(i_addr, sdd_pkg::ADDR_BP_DIR);
    wire wr_col_dir = i_wr && sdd_pkg::reg_hit(i_addr, sdd_pkg::ADDR_COL_DIR);
    wire wr_bp_out = i_wr && sdd_pkg::reg_hit(i_addr, sdd_pkg::ADDR_BP_OUT);
    wire wr_col_out = i_wr && sdd_pkg::reg_hit(i_addr, sdd_pkg::ADDR_COL_OUT);
    wire pix_hit = (i_addr[7:3] == sdd_pkg::ADDR_PIX_BASE[7:3]);
    wire wr_pix = i_wr && pix_hit;

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_reg <= sdd_pkg::sdd_ctrl_type'(sdd_pkg::CTRL_RST[6:0]);
            presc_reg <= sdd_pkg::PRESC_RST;
            seg_en_reg <= sdd_pkg::SEG_EN_RST;
            bp_dir_reg <= sdd_pkg::DIR_RST;
            col_dir_reg <= sdd_pkg::DIR_RST;
            bp_out_reg <= sdd_pkg::OUT_RST;
            col_out_reg <= sdd_pkg::OUT_RST;
        end else if (i_ce) begin
            if (wr_ctrl) begin
                ctrl_reg.en <= i_wdata[sdd_pkg::CTRL_EN_BIT];
                ctrl_reg.src_lf <= i_wdata[sdd_pkg::CTRL_SRC_BIT];
                ctrl_reg.type_b <= i_wdata[sdd_pkg::CTRL_TYPEB_BIT];
                ctrl_reg.sel <= i_wdata[sdd_pkg::CTRL_SEL_LSB +: 4];
            end
            if (wr_presc) presc_reg <= i_wdata[3:0];
            if (wr_seg) seg_en_reg <= i_wdata;
            if (wr_bp_dir) bp_dir_reg <= i_wdata;
            if (wr_col_dir) col_dir_reg <= i_wdata;
            if (wr_bp_out) bp_out_reg <= i_wdata;
            if (wr_col_out) col_out_reg <= i_wdata;
        end
    end

    // image memory has no reset; software loads it before enabling
    always_ff @(posedge i_core_clk) begin
        if (i_ce && wr_pix) begin
            pix_reg[i_addr[2:0]] <= i_wdata;
        end
    end

    // ****************************************************************
    // read port
    // ****************************************************************
    wire [7:0] status = {3'h0, frame_odd_reg, phase_reg, bp_idx_reg};
    wire [7:0] rd_mux =
        sdd_pkg::reg_hit(i_addr, sdd_pkg::ADDR_CTRL) ?
            {ctrl_reg.en, 1'b0, ctrl_reg.src_lf, ctrl_reg.type_b, ctrl_reg.sel} :
        sdd_pkg::reg_hit(i_addr, sdd_pkg::ADDR_PRESC) ? {4'h0, presc_reg} :
        sdd_pkg::reg_hit(i_addr, sdd_pkg::ADDR_SEG_EN) ? seg_en_reg :
        sdd_pkg::reg_hit(i_addr, sdd_pkg::ADDR_BP_DIR) ? bp_dir_reg :
        sdd_pkg::reg_hit(i_addr, sdd_pkg::ADDR_COL_DIR) ? col_dir_reg :
        sdd_pkg::reg_hit(i_addr, sdd_pkg::ADDR_BP_OUT) ? bp_out_reg :
        sdd_pkg::reg_hit(i_addr, sdd_pkg::ADDR_COL_OUT) ? col_out_reg :
        sdd_pkg::reg_hit(i_addr, sdd_pkg::ADDR_STATUS) ? status :
        sdd_pkg::reg_hit(i_addr, sdd_pkg::ADDR_BP_IN) ? i_bp_pin_in :
        sdd_pkg::reg_hit(i_addr, sdd_pkg::ADDR_COL_IN) ? i_col_pin_in :
        pix_hit ? pix_reg[i_addr[2:0]] : 8'h00;

    // data stands only in the cycle after the read strobe
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= 8'h00;
        end else if (i_ce) begin
            o_rdata <= i_rd ? rd_mux : 8'h00;
        end
    end

    // ****************************************************************
    // frame timing
    // ****************************************************************
    sdd_frame_div u_frame_div (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .i_src_lf(ctrl_reg.src_lf),
        .i_secondary_oscillator(i_secondary_oscillator),
        .i_lfosc(i_lfosc),
        .o_tick(tick)
    );

    wire [3:0] n_bp = sdd_pkg::num_bp(ctrl_reg.sel);
    wire [2:0] k_fac = (n_bp == 4'h1) ? sdd_pkg::K_STATIC :
                       (n_bp == 4'h2) ? sdd_pkg::K_HALF : sdd_pkg::K_MULTI;
    wire [6:0] slice_len = 7'({4'h0, k_fac} * ({3'h0, presc_reg} + 7'h01));
    wire [6:0] half_len = slice_len >> 1;
    wire run = ctrl_reg.en && (n_bp != 4'h0);
    wire slice_end = run && tick && (slice_cnt_reg == slice_len - 7'h01);
    wire frame_end = slice_end && ({1'b0, bp_idx_reg} == n_bp - 4'h1);
    wire mid_slice = run && tick && (half_len != 7'h00) && (slice_cnt_reg + 7'h01 == half_len);

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            slice_cnt_reg <= 7'h00;
            bp_idx_reg <= 3'h0;
            phase_reg <= 1'b0;
            frame_odd_reg <= 1'b0;
        end else if (i_ce) begin
            // a new setting restarts the frame, so no counter is left beyond a shorter slice or frame
            if (!run || wr_ctrl || wr_presc) begin
                slice_cnt_reg <= 7'h00;
                bp_idx_reg <= 3'h0;
                phase_reg <= 1'b0;
            end else if (tick) begin
                slice_cnt_reg <= slice_end ? 7'h00 : slice_cnt_reg + 7'h01;
                if (slice_end) begin
                    bp_idx_reg <= frame_end ? 3'h0 : bp_idx_reg + 3'h1;
                end
                if (ctrl_reg.type_b ? frame_end : (slice_end || mid_slice)) begin
                    phase_reg <= !phase_reg;
                end
                if (frame_end) frame_odd_reg <= !frame_odd_reg;
            end
        end
    end

    // ****************************************************************
    // drive levels and pins
    // ****************************************************************
    logic [15:0] bp_lvl;
    logic [15:0] col_lvl;
    sdd_pkg::sdd_pin_type [7:0] bp_pin_next;
    sdd_pkg::sdd_pin_type [7:0] col_pin_next;

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_lvl
            // inverting both sides each phase keeps the net DC at zero in type B and in type A with an even slice length
            assign bp_lvl[2*g+1 -: 2] = run ?
                sdd_pkg::bp_level(bp_idx_reg == 3'(g), phase_reg) : sdd_pkg::LVL_0;
            assign col_lvl[2*g+1 -: 2] = run ?
                sdd_pkg::col_level(pix_reg[bp_idx_reg][g], phase_reg) : sdd_pkg::LVL_0;
        end
    endgenerate

    sdd_pin_mux #(.W(8)) u_bp_mux (
        .i_lcd_en(sdd_pkg::bp_mask(ctrl_reg.sel)),
        .i_dir(bp_dir_reg),
        .i_out(bp_out_reg),
        .i_level(bp_lvl),
        .o_pin(bp_pin_next)
    );

    sdd_pin_mux #(.W(8)) u_col_mux (
        .i_lcd_en(seg_en_reg),
        .i_dir(col_dir_reg),
        .i_out(col_out_reg),
        .i_level(col_lvl),
        .o_pin(col_pin_next)
    );

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_bp_pin <= '{default: sdd_pkg::sdd_pin_type'{lcd: 1'b0, oe_n: 1'b1, out: 1'b0, level: 2'h0}};
            o_col_pin <= '{default: sdd_pkg::sdd_pin_type'{lcd: 1'b0, oe_n: 1'b1, out: 1'b0, level: 2'h0}};
        end else if (i_ce) begin
            o_bp_pin <= bp_pin_next;
            o_col_pin <= col_pin_next;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    logic [7:0] frm_tick_cnt;
    logic cfg_stable;

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            frm_tick_cnt <= 8'h00;
            cfg_stable <= 1'b0;
        end else if (i_ce) begin
            if (wr_ctrl || wr_presc || !run) begin
                cfg_stable <= 1'b0;
                frm_tick_cnt <= 8'h00;
            end else if (tick) begin
                frm_tick_cnt <= frame_end ? 8'h00 : frm_tick_cnt + 8'h01;
                if (frame_end) cfg_stable <= 1'b1;
            end
        end
    end

    chk_sel_write: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (i_ce && wr_ctrl) |=> (ctrl_reg.sel == $past(i_wdata[3:0])))
        else $error("backplane count select not stored");
    chk_bp_assign: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        i_ce |=> (o_bp_pin[7].lcd == ($past(ctrl_reg.sel) == 4'h8))
              && (o_bp_pin[0].lcd == ($past(ctrl_reg.sel) != 4'h0 && $past(ctrl_reg.sel) <= 4'h8)))
        else $error("backplane pin function does not follow select");
    chk_bp_dir_ignored: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (i_ce && ctrl_reg.sel != 4'h0 && ctrl_reg.sel <= 4'h8) |=> !o_bp_pin[0].oe_n)
        else $error("backplane pin obeys its direction bit");
    chk_gpio_dir: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (i_ce && !seg_en_reg[1]) |=> (o_col_pin[1].oe_n == $past(col_dir_reg[1])))
        else $error("general i/o pin ignores its direction bit");
    chk_reset_clear: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        $rose(i_rstn) |-> (ctrl_reg.sel == 4'h0) && (seg_en_reg == 8'h00) && !o_col_pin[0].lcd)
        else $error("display pins not general i/o after reset");
    chk_seg_override: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (i_ce && seg_en_reg[0] && col_dir_reg[0]) |=> o_col_pin[0].lcd && !o_col_pin[0].oe_n)
        else $error("segment enable does not take the pin");
    chk_pixel_store: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (i_ce && wr_pix) |=> (pix_reg[$past(i_addr[2:0])] == $past(i_wdata)))
        else $error("pixel bits not stored");
    chk_pixel_drive: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (i_ce && run && bp_idx_reg == 3'h0 && ctrl_reg.sel != 4'h0 && seg_en_reg[0])
        |=> ((o_bp_pin[0].level ^ o_col_pin[0].level) == ($past(pix_reg[0][0]) ? 2'h3 : 2'h1)))
        else $error("pixel drive amplitude wrong for active backplane");
    chk_frame_len: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (i_ce && frame_end && cfg_stable && !wr_ctrl && !wr_presc)
        |-> (11'(frm_tick_cnt) + 11'h001 == 11'(k_fac) * 11'(n_bp) * (11'(presc_reg) + 11'h001)))
        else $error("frame length differs from divider formula");
    chk_type_a_mid: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (i_ce && slice_end && !ctrl_reg.type_b && cfg_stable && half_len != 7'h00 && !wr_ctrl)
        |-> phase_reg)
        else $error("type A phase did not reverse inside the slice");
    chk_type_b_hold: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (i_ce && run && ctrl_reg.type_b && !frame_end && !wr_ctrl && !wr_presc) |=> $stable(phase_reg))
        else $error("type B phase changed inside a frame");

endmodule : sdd_top
